// File: logic/smrs_top.sv
// supply supervision, reset sequencing, diagnosis flags and output gating
// Behaviour
// - logic/analog/reference undervoltage holds internal reset
// - missing clock resets only when watchdog enabled
// - release after supplies good plus POR delay
// - set reset-occurred flag on every reset exit
// - diagnosis register access clears reset-occurred flag
// - load undervoltage: channel off, channel flag set
// - pump undervoltage: all outputs off, flag set
// - pump below warning threshold sets warning flag
// - pump warning alone never disables channels
// - sleep while core supply low, auto exit
// - sleep exit runs full init with delay
// - enable low: channels off, fault if mask
// - load undervoltage fault output only if masked
// - battery overvoltage: channels off, fault low
// - reset pin low: reset, fault low, serial off
// - POR delay starts cycle after pin release
// - watchdog fault: reads ident, writes blocked
// - enable low clears set-point enables until rewritten
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "smrs_defs.svh"
module smrs_top
  import smrs_pkg::*;
#(
  parameter int NCH = `SMRS_NCH,
  parameter int POR_EXT_CYCLES = `SMRS_T_POR_EXT_NS * 1000 / `SMRS_CLK_PERIOD_PS,
  parameter int POR_UV_CYCLES = `SMRS_POR_UV_CLK_CYCLES,
  parameter logic [`SMRS_IDENT_VER_W-1:0] IDENT_VERSION = `SMRS_IDENT_VERSION
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // supply comparators; the OK inputs are high when supply above threshold, the others are high on fault
  input wire logic LOGIC_SUPPLY_OK,
  input wire logic ANALOG_SUPPLY_OK,
  input wire logic REFERENCE_SUPPLY_OK,
  input wire logic [NCH-1:0] LOAD_SUPPLY_OK,
  input wire logic PUMP_UNDERVOLTAGE,
  input wire logic PUMP_WARNING,
  input wire logic BATTERY_OVERVOLTAGE,
  input wire logic CLOCK_MISSING,
  // pins
  input wire logic EXT_RESET_N,
  input wire logic ENABLE_PIN,
  output logic FAULT_OUT_N_O,
  output logic FAULT_OUT_N_OE,
  // register port
  input wire logic [`SMRS_ADDR_W-1:0] ADDR,
  input wire logic [`SMRS_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`SMRS_DATA_W-1:0] RDATA,
  // to the rest of the chip
  output logic LOGIC_RESET,
  output logic SLEEP_MODE,
  output logic WATCHDOG_FAULT,
  output logic [NCH-1:0] STAGE_ENABLE
);
  localparam int CNT_W = $clog2(((POR_UV_CYCLES > POR_EXT_CYCLES) ? POR_UV_CYCLES : POR_EXT_CYCLES) + 1);
  localparam int SYNC_W = NCH + 9;

  logic [SYNC_W-1:0] sync_q;
  logic [2:0] core_ok_s;
  logic [NCH-1:0] load_ok_s;
  logic pump_uv_s;
  logic pump_warn_s;
  logic bat_ov_s;
  logic clk_missing_s;
  logic ext_n_s;
  logic en_pin_s;
  logic supplies_ok;
  smrs_state_t state_r;
  smrs_state_t state_nxt;
  logic [CNT_W-1:0] por_cnt_r;
  logic run;
  logic rst_exit;
  logic diag_access;
  logic wr_ok;
  logic rd_ok;
  logic [`SMRS_DATA_W-1:0] ctrl_r;
  logic [NCH-1:0] setpt_en_r;
  logic diag_rst_r;
  logic diag_puv_r;
  logic diag_pwarn_r;
  logic diag_bov_r;
  logic [NCH-1:0] diag_lsuv_r;
  logic wd_en;
  logic enable_pin_fault_mask;
  logic [NCH-1:0] ch_mask;
  logic fault_nxt;
  logic [`SMRS_DATA_W-1:0] rd_mux;

  // every comparator level crosses into the clock through two flops
  smrs_sync #(
    .W(SYNC_W)
  ) smrs_sync_inst (
    .clk(CORE_CLK),
    .rst(RESET),
    .d({LOGIC_SUPPLY_OK, ANALOG_SUPPLY_OK, REFERENCE_SUPPLY_OK, LOAD_SUPPLY_OK, PUMP_UNDERVOLTAGE,
        PUMP_WARNING, BATTERY_OVERVOLTAGE, CLOCK_MISSING, EXT_RESET_N, ENABLE_PIN}),
    .q(sync_q)
  );

  assign {core_ok_s, load_ok_s, pump_uv_s, pump_warn_s, bat_ov_s, clk_missing_s, ext_n_s, en_pin_s} = sync_q;
  assign supplies_ok = &core_ok_s;
  assign run = (state_r == SMRS_RUN);
  assign wd_en = ctrl_r[`SMRS_CTRL_CLOCK_WATCHDOG_ENABLE];
  assign enable_pin_fault_mask = ctrl_r[`SMRS_CTRL_FME];
  assign ch_mask = ctrl_r[`SMRS_CTRL_FM_LSB +: NCH];

  // sequencing; supply loss outranks the pin, the pin outranks the watchdog
  always_comb begin
    state_nxt = state_r;
    if (!supplies_ok) begin
      state_nxt = SMRS_SLEEP;
    end else if (!ext_n_s) begin
      state_nxt = SMRS_RESET_HOLD;
    end else begin
      unique case (state_r)
        SMRS_SLEEP: state_nxt = SMRS_POR_WAIT;
        SMRS_RESET_HOLD: state_nxt = SMRS_POR_WAIT;
        SMRS_POR_WAIT: begin
          if (por_cnt_r == '0) begin
            state_nxt = SMRS_RUN;
          end
        end
        SMRS_RUN: begin
          if (wd_en && clk_missing_s) begin
            state_nxt = SMRS_WD_FAULT;
          end
        end
        SMRS_WD_FAULT: state_nxt = SMRS_WD_FAULT;
        default: state_nxt = SMRS_SLEEP;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= SMRS_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // preloaded while held, so counting starts the first cycle after release
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      por_cnt_r <= CNT_W'(POR_UV_CYCLES - 1);
    end else if (state_r == SMRS_SLEEP) begin
      por_cnt_r <= CNT_W'(POR_UV_CYCLES - 1);
    end else if (state_r == SMRS_RESET_HOLD) begin
      por_cnt_r <= CNT_W'(POR_EXT_CYCLES - 1);
    end else if (state_r == SMRS_POR_WAIT && por_cnt_r != '0) begin
      por_cnt_r <= por_cnt_r - 1'b1;
    end
  end

  assign rst_exit = (state_r == SMRS_POR_WAIT) && (state_nxt == SMRS_RUN);
  // serial port is dead until the delay is over; a watchdog fault leaves reads only
  assign wr_ok = WR && run;
  assign rd_ok = RD && (run || state_r == SMRS_WD_FAULT);
  assign diag_access = (WR || RD) && run && (ADDR == `SMRS_OFS_DIAG);

  // configuration falls back to reset values whenever the logic is in reset
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_r <= '0;
    end else if (!run) begin
      ctrl_r <= '0;
    end else if (wr_ok && ADDR == `SMRS_OFS_CTRL) begin
      ctrl_r <= WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      setpt_en_r <= '0;
    end else if (!run || !en_pin_s) begin
      setpt_en_r <= '0;
    end else if (wr_ok && ADDR == `SMRS_OFS_SETPT) begin
      setpt_en_r <= WDATA[NCH-1:0];
    end
  end

  // reset-occurred flag: the exit set wins over an access clear
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      diag_rst_r <= 1'b0;
    end else if (rst_exit) begin
      diag_rst_r <= 1'b1;
    end else if (!run || diag_access) begin
      diag_rst_r <= 1'b0;
    end
  end

  // sticky fault flags, set only while diagnostics run; set wins over clear
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      diag_puv_r <= 1'b0;
      diag_pwarn_r <= 1'b0;
      diag_bov_r <= 1'b0;
      diag_lsuv_r <= '0;
    end else if (!run) begin
      diag_puv_r <= 1'b0;
      diag_pwarn_r <= 1'b0;
      diag_bov_r <= 1'b0;
      diag_lsuv_r <= '0;
    end else begin
      diag_puv_r <= pump_uv_s | (diag_puv_r & ~diag_access);
      diag_pwarn_r <= pump_warn_s | (diag_pwarn_r & ~diag_access);
      diag_bov_r <= bat_ov_s | (diag_bov_r & ~diag_access);
      diag_lsuv_r <= ~load_ok_s | (diag_lsuv_r & {NCH{~diag_access}});
    end
  end

  always_comb begin
    rd_mux = '0;
    if (state_r == SMRS_WD_FAULT) begin
      rd_mux[`SMRS_IDENT_VER_W-1:0] = IDENT_VERSION;
      rd_mux[`SMRS_IDENT_WDST] = 1'b1;
    end else begin
      unique case (ADDR)
        `SMRS_OFS_DIAG: begin
          rd_mux[`SMRS_DIAG_RST] = diag_rst_r;
          rd_mux[`SMRS_DIAG_PUV] = diag_puv_r;
          rd_mux[`SMRS_DIAG_PWARN] = diag_pwarn_r;
          rd_mux[`SMRS_DIAG_BOV] = diag_bov_r;
          rd_mux[`SMRS_DIAG_LSUV_LSB +: NCH] = diag_lsuv_r;
        end
        `SMRS_OFS_CTRL: rd_mux = ctrl_r;
        `SMRS_OFS_SETPT: rd_mux[NCH-1:0] = setpt_en_r;
        `SMRS_OFS_IDENT: rd_mux[`SMRS_IDENT_VER_W-1:0] = IDENT_VERSION;
        `SMRS_OFS_STATUS: begin
          rd_mux[2:0] = state_r;
          rd_mux[`SMRS_STATUS_EN] = en_pin_s;
          rd_mux[`SMRS_STATUS_SUP_LSB +: 3] = core_ok_s;
        end
        default: rd_mux = '0;
      endcase
    end
  end

  // unmapped addresses outside a watchdog fault and reads while disabled return zero
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else if (rd_ok) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= '0;
    end
  end

  // pump warning is deliberately absent from the gate
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      STAGE_ENABLE <= '0;
    end else begin
      STAGE_ENABLE <= {NCH{run && en_pin_s && !pump_uv_s && !bat_ov_s}}
                      & load_ok_s & setpt_en_r;
    end
  end

  // reset and sleep pull the pin regardless of masks
  assign fault_nxt = !run || bat_ov_s || pump_uv_s
                     || (!en_pin_s && enable_pin_fault_mask)
                     || (|(~load_ok_s & ch_mask));

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      FAULT_OUT_N_OE <= 1'b1;
      FAULT_OUT_N_O <= 1'b0;
    end else begin
      FAULT_OUT_N_OE <= fault_nxt;
      FAULT_OUT_N_O <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      LOGIC_RESET <= 1'b1;
      SLEEP_MODE <= 1'b1;
      WATCHDOG_FAULT <= 1'b0;
    end else begin
      LOGIC_RESET <= (state_nxt != SMRS_RUN);
      SLEEP_MODE <= (state_nxt == SMRS_SLEEP);
      WATCHDOG_FAULT <= (state_nxt == SMRS_WD_FAULT);
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  a_core_supply_reset: assert property (
    !supplies_ok |=> LOGIC_RESET && SLEEP_MODE && state_r == SMRS_SLEEP)
    else $error("core supply low without reset");

  a_wd_gated_reset: assert property (
    run && clk_missing_s && supplies_ok && ext_n_s |=> (state_r == SMRS_WD_FAULT) == $past(wd_en))
    else $error("watchdog reset not tied to enable bit");

  a_release_after_delay: assert property (
    $fell(LOGIC_RESET) |-> $past(state_r) == SMRS_POR_WAIT && $past(por_cnt_r) == '0)
    else $error("reset released before delay elapsed");

  a_rst_flag_set: assert property (
    $rose(run) |-> diag_rst_r)
    else $error("reset-occurred flag missing on exit");

  a_rst_flag_clear: assert property (
    diag_access && !rst_exit |=> !diag_rst_r)
    else $error("reset-occurred flag survived access");

  a_load_uv_off: assert property (
    run && !load_ok_s[0] && state_nxt == SMRS_RUN |=> !STAGE_ENABLE[0] && diag_lsuv_r[0])
    else $error("load undervoltage not handled");

  a_pump_uv_off: assert property (
    pump_uv_s |=> STAGE_ENABLE == '0 && FAULT_OUT_N_OE)
    else $error("pump undervoltage left outputs on");

  a_pump_warn_only: assert property (
    run && pump_warn_s && !pump_uv_s && !bat_ov_s && en_pin_s && state_nxt == SMRS_RUN
    |=> STAGE_ENABLE == ($past(load_ok_s) & $past(setpt_en_r)))
    else $error("pump warning gated a channel");

  a_en_low_clears: assert property (
    !en_pin_s |=> STAGE_ENABLE == '0 && setpt_en_r == '0)
    else $error("enable low left channel on");

  a_por_from_pin: assert property (
    state_r == SMRS_RESET_HOLD && state_nxt == SMRS_POR_WAIT
    |=> por_cnt_r == CNT_W'(POR_EXT_CYCLES - 1) ##1 por_cnt_r == CNT_W'(POR_EXT_CYCLES - 2))
    else $error("delay did not start after pin release");

  a_wd_no_write: assert property (
    state_r == SMRS_WD_FAULT && $past(state_r) == SMRS_WD_FAULT && RD
    |=> RDATA[`SMRS_IDENT_VER_W-1:0] == IDENT_VERSION && RDATA[`SMRS_IDENT_WDST] && $stable(ctrl_r))
    else $error("watchdog fault read or write wrong");

  a_fault_in_reset: assert property (
    LOGIC_RESET |=> FAULT_OUT_N_OE)
    else $error("fault pin released during reset");

  c_reach_run: cover property ($rose(run));
  c_wd_trip: cover property (run ##1 state_r == SMRS_WD_FAULT);
  c_sleep_exit: cover property (state_r == SMRS_SLEEP ##1 state_r == SMRS_POR_WAIT);
  c_diag_clear: cover property (diag_access && diag_rst_r);
endmodule // smrs_top

// File: logic/smrs_defs.svh
// register offsets, field positions and timing of the supply monitor
`ifndef SMRS_DEFS_SVH
`define SMRS_DEFS_SVH

`define SMRS_ADDR_W 8
`define SMRS_DATA_W 16

`define SMRS_OFS_DIAG 8'h00
`define SMRS_OFS_CTRL 8'h04
`define SMRS_OFS_SETPT 8'h08
`define SMRS_OFS_IDENT 8'h0c
`define SMRS_OFS_STATUS 8'h10

`define SMRS_DIAG_RST 0
`define SMRS_DIAG_PUV 1
`define SMRS_DIAG_PWARN 2
`define SMRS_DIAG_BOV 3
`define SMRS_DIAG_LSUV_LSB 4

`define SMRS_CTRL_CLOCK_WATCHDOG_ENABLE 0
`define SMRS_CTRL_FME 1
`define SMRS_CTRL_FM_LSB 2

`define SMRS_IDENT_WDST 8
`define SMRS_IDENT_VER_W 8
// arbitrary identification value
`define SMRS_IDENT_VERSION 8'h5a

`define SMRS_STATUS_EN 3
`define SMRS_STATUS_SUP_LSB 4

`define SMRS_NCH 3
`define SMRS_CLK_PERIOD_PS 4000
`define SMRS_T_POR_EXT_NS 100000
`define SMRS_POR_UV_CLK_CYCLES 65536

`endif

// File: logic/smrs_pkg.sv
// types of the supply monitor and reset sequencer
package smrs_pkg;
  typedef enum logic [2:0] {
    SMRS_SLEEP,
    SMRS_RESET_HOLD,
    SMRS_POR_WAIT,
    SMRS_RUN,
    SMRS_WD_FAULT
  } smrs_state_t;
endpackage

// File: logic/smrs_sync.sv
// two-flop synchroniser bank for comparator and pin levels
`timescale 1ns/10ps
module smrs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // zero at reset reads as "supply low" and "pin low": the safe side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // smrs_sync

// File: testbench/smrs_pin_model.sv
// open-drain fault pin with its external pull-up resistor to the io supply
`timescale 1ns/10ps
module smrs_pin_model (
  // supply of the pull-up
  input wire logic io_supply,
  // design side of the pin
  input wire logic fault_o,
  input wire logic fault_oe,
  // resolved wire as the host sees it
  output logic fault_out_n
);
  // released pin follows the resistor, never the last driven value
  assign fault_out_n = fault_oe ? fault_o : io_supply;
endmodule // smrs_pin_model

// File: testbench/smrs_top_tb_top.sv
// self-checking bench of the supply monitor and reset sequencer
`timescale 1ns/10ps
`include "smrs_defs.svh"
module smrs_top_tb_top;
  localparam int PEXT = 20;
  localparam int PUV = 30;
  localparam logic [15:0] IDENT = {7'h00, 1'b1, `SMRS_IDENT_VERSION};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sup = 3'h7;
  logic [2:0] load = 3'h7;
  logic puv = 1'b0;
  logic pwarn = 1'b0;
  logic bov = 1'b0;
  logic cmiss = 1'b0;
  logic rstn = 1'b1;
  logic en = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic fo, foe, lrst, slp, wdf, fpin;
  logic [2:0] stage;
  logic [2:0] r;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 91;
  int m_setpt = 0;
  int exp_q[$];

  smrs_top #(.POR_EXT_CYCLES(PEXT), .POR_UV_CYCLES(PUV)) smrs_top_inst (
    .CORE_CLK(clk), .RESET(rst), .LOGIC_SUPPLY_OK(sup[2]), .ANALOG_SUPPLY_OK(sup[1]),
    .REFERENCE_SUPPLY_OK(sup[0]), .LOAD_SUPPLY_OK(load), .PUMP_UNDERVOLTAGE(puv), .PUMP_WARNING(pwarn),
    .BATTERY_OVERVOLTAGE(bov), .CLOCK_MISSING(cmiss), .EXT_RESET_N(rstn), .ENABLE_PIN(en),
    .FAULT_OUT_N_O(fo), .FAULT_OUT_N_OE(foe), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LOGIC_RESET(lrst), .SLEEP_MODE(slp), .WATCHDOG_FAULT(wdf), .STAGE_ENABLE(stage));
  smrs_pin_model smrs_pin_model_inst (.io_supply(1'b1), .fault_o(fo), .fault_oe(foe), .fault_out_n(fpin));

  always #2 clk = ~clk;
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(int'(e));
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, 16'(exp_q.pop_front()), rdata);
  endtask
  // rule model of the stage gates: pump warning has no say
  function automatic logic [2:0] m_stage();
    int s;
    s = 0;
    if (en && !puv && !bov) s = int'(load) & m_setpt;
    return 3'(s);
  endfunction
  task automatic bit1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask
  // host holds off the register port until internal reset drops
  task automatic wait_run(input string nm, input int p);
    int k;
    k = 0;
    while (lrst !== 1'b0 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    bit1(nm, 1'b1, k >= p && k <= p + 6);
  endtask

  initial begin
    repeat (9) @(posedge clk);
    #1;
    bit1("fault in reset", 1'b0, fpin);
    @(posedge clk);
    rst <= 1'b0;
    wait_run("power-up delay", PUV);
    rchk("reset flag", `SMRS_OFS_DIAG, 16'h0001);
    rchk("reset flag cleared", `SMRS_OFS_DIAG, 16'h0000);
    rchk("ident in run", `SMRS_OFS_IDENT, {8'h00, `SMRS_IDENT_VERSION});
    rchk("status in run", `SMRS_OFS_STATUS, 16'h007b);
    wreg(`SMRS_OFS_CTRL, 16'h001e);
    wreg(`SMRS_OFS_SETPT, 16'h0007);
    m_setpt = 7;
    rchk("ctrl readback", `SMRS_OFS_CTRL, 16'h001e);
    rchk("set-point readback", `SMRS_OFS_SETPT, 16'h0007);
    w(5);
    chk("stages on", {13'h0, m_stage()}, {13'h0, stage});
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      r = 3'($random(seed));
      @(posedge clk);
      load <= r;
      w(5);
      chk("load gating", {13'h0, m_stage()}, {13'h0, stage});
      bit1("load fault pin", &r, fpin);
      rchk("load flags", `SMRS_OFS_DIAG, {9'h0, ~r, 4'h0});
      @(posedge clk);
      load <= 3'h7;
      w(5);
      rchk("load flags sticky", `SMRS_OFS_DIAG, {9'h0, ~r, 4'h0});
    end
    $display("test load supply done");
    @(posedge clk);
    pwarn <= 1'b1;
    w(5);
    chk("warning keeps stages", {13'h0, m_stage()}, {13'h0, stage});
    rchk("warning flag", `SMRS_OFS_DIAG, 16'h0004);
    @(posedge clk);
    puv <= 1'b1;
    w(5);
    chk("pump low stages", {13'h0, m_stage()}, {13'h0, stage});
    bit1("pump low fault", 1'b0, fpin);
    rchk("pump flags", `SMRS_OFS_DIAG, 16'h0006);
    @(posedge clk);
    puv <= 1'b0; pwarn <= 1'b0; bov <= 1'b1;
    w(5);
    chk("overvoltage stages", {13'h0, m_stage()}, {13'h0, stage});
    bit1("overvoltage fault", 1'b0, fpin);
    rchk("overvoltage flag", `SMRS_OFS_DIAG, 16'h000e);
    @(posedge clk);
    bov <= 1'b0; en <= 1'b0;
    m_setpt = 0;
    w(5);
    chk("enable low stages", {13'h0, m_stage()}, {13'h0, stage});
    bit1("enable low masked", 1'b0, fpin);
    rchk("set-point cleared", `SMRS_OFS_SETPT, 16'h0000);
    @(posedge clk);
    en <= 1'b1;
    w(5);
    rchk("set-point stays clear", `SMRS_OFS_SETPT, 16'h0000);
    wreg(`SMRS_OFS_CTRL, 16'h0000);
    @(posedge clk);
    en <= 1'b0;
    w(5);
    bit1("enable low unmasked", 1'b1, fpin);
    $display("test pump and enable done");
    @(posedge clk);
    en <= 1'b1; cmiss <= 1'b1;
    w(5);
    bit1("watchdog off", 1'b0, wdf);
    bit1("no reset when off", 1'b0, lrst);
    wreg(`SMRS_OFS_CTRL, 16'h0001);
    w(5);
    bit1("watchdog fault", 1'b1, wdf);
    bit1("watchdog fault pin", 1'b0, fpin);
    wreg(`SMRS_OFS_CTRL, 16'h0002);
    rchk("ident on ctrl read", `SMRS_OFS_CTRL, IDENT);
    @(posedge clk);
    cmiss <= 1'b0;
    w(5);
    rchk("ident after clock returns", `SMRS_OFS_DIAG, IDENT);
    @(posedge clk);
    rstn <= 1'b0;
    w(5);
    bit1("pin reset", 1'b1, lrst);
    bit1("pin reset fault", 1'b0, fpin);
    rchk("serial off", `SMRS_OFS_STATUS, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    wait_run("pin release delay", PEXT);
    bit1("watchdog cleared", 1'b0, wdf);
    rchk("reset flag after pin", `SMRS_OFS_DIAG, 16'h0001);
    $display("test watchdog and pin done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sup[i] <= 1'b0;
      w(5);
      bit1("sleep entry", 1'b1, slp);
      bit1("supply reset", 1'b1, lrst);
      bit1("sleep fault", 1'b0, fpin);
      @(posedge clk);
      sup <= 3'h7;
      wait_run("sleep exit delay", PUV);
      bit1("sleep left", 1'b0, slp);
      rchk("reset flag after sleep", `SMRS_OFS_DIAG, 16'h0001);
    end
    $display("test sleep done");
    wrap_up();
  end
endmodule // smrs_top_tb_top
